/* hw/fbp_pkg.sv */
// Purpose: Shared constants, types and functions of the block protection register.
// Assumes: Byte-wide register port; two memory blocks, each with its own banked copy.
// Notes:   Scenario index is {function, high disable, low disable}.

package fbp_pkg;

    localparam int NUM_BLOCKS = 2;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_PROT   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;

    localparam int BIT_BANK   = 0;
    localparam int BIT_VIOL   = 5;
    localparam int BIT_LOADED = 7;

    localparam logic [DATA_W-1:0] PROT_RESET_VAL = 8'hff;
    localparam logic [DATA_W-1:0] READ_ZERO      = 8'h00;

    // ----------------------------------------------------------------
    // Configuration memory and address windows
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_ADDR_BLK0 = 16'hff0d;
    localparam logic [15:0] CFG_ADDR_BLK1 = 16'hff0c;

    localparam logic [16:0] HIGH_MIN_BYTES   = 17'h00800;
    localparam logic [16:0] LOW_MIN_BYTES    = 17'h00400;
    localparam logic [16:0] UNPAGED_HIGH_END = 17'h10000;
    localparam logic [16:0] PAGED_HIGH_END   = 17'h0d000;
    localparam logic [16:0] UNPAGED_LOW_BASE = 17'h04000;
    localparam logic [16:0] PAGED_LOW_BASE   = 17'h08000;
    localparam logic [7:0]  PAGE_HIGH_A      = 8'h37;
    localparam logic [7:0]  PAGE_HIGH_B      = 8'h3f;
    localparam logic [7:0]  PAGE_LOW_A       = 8'h36;
    localparam logic [7:0]  PAGE_LOW_B       = 8'h3e;

    localparam logic [2:0]  SCEN_OPEN = 3'h7;

    // Row r, bit c set: moving from scenario r to scenario c is allowed.
    localparam logic [63:0] TRANS_ALLOW = 64'hff_5a_3c_18_08_0c_0a_0f;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       func;
        logic       rsvd;
        logic       hdis;
        logic [1:0] hsize;
        logic       ldis;
        logic [1:0] lsize;
    } fbp_prot_type;

    typedef enum logic [1:0] {
        OP_PROGRAM     = 2'h0,
        OP_SECTOR_ERASE = 2'h1,
        OP_MASS_ERASE  = 2'h2
    } fbp_op_kind_type;

    typedef struct packed {
        fbp_op_kind_type kind;
        logic            block;
        logic            paged;
        logic [7:0]      page;
        logic [15:0]     addr;
    } fbp_op_req_type;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [2:0] fbp_scenario(input fbp_prot_type p);
        fbp_scenario = {p.func, p.hdis, p.ldis};
    endfunction : fbp_scenario

    function automatic logic fbp_trans_ok(input logic [2:0] from_s, input logic [2:0] to_s);
        fbp_trans_ok = TRANS_ALLOW[{from_s, to_s}];
    endfunction : fbp_trans_ok

endpackage : fbp_pkg

/* hw/fbp_protect.sv */
// Purpose: Banked block protection registers, reset loading and operation screening.
// Assumes: Configuration memory answers a read one cycle after cfg_rd.
// Notes:   Registers are loaded right after reset release; operations are refused until it ends.
`timescale 1ns/1ps

module fbp_protect
    import fbp_pkg::*;
(
    input  logic              clk,          // 100 MHz clock
    input  logic              reset,        // Synchronous reset, active high
    input  logic [ADDR_W-1:0] reg_addr,     // Register address
    input  logic [DATA_W-1:0] reg_wdata,    // Register write data
    input  logic              reg_wr,       // Write strobe
    input  logic              reg_rd,       // Read strobe
    output logic [DATA_W-1:0] reg_rdata,    // Read data, cycle after read strobe
    output logic              cfg_rd,       // Configuration memory read request
    output logic [15:0]       cfg_addr,     // Configuration memory address
    input  logic [DATA_W-1:0] cfg_data,     // Configuration byte, cycle after request
    input  logic              op_valid,     // Operation request pulse
    input  fbp_op_req_type    op_req,       // Operation description
    output logic              op_done,      // Operation screened pulse
    output logic              op_refused,   // Operation refused, with op_done
    output logic              loaded        // Reset loading has finished
);

    // ----------------------------------------------------------------
    // Load sequencer
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_FETCH0 = 5'b00001,
        ST_FETCH1 = 5'b00010,
        ST_CAP0   = 5'b00100,
        ST_CAP1   = 5'b01000,
        ST_RUN    = 5'b10000
    } fbp_state_type;

    fbp_state_type     st_q;
    fbp_state_type     st_d;
    fbp_prot_type      prot_q [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0] viol_q;
    logic              bank_sel_q;
    logic [DATA_W-1:0] rdata_q;
    logic              cfg_rd_q;
    logic [15:0]       cfg_addr_q;
    logic              op_done_q;
    logic              op_refused_q;
    logic              loaded_q;

    fbp_prot_type      wr_next;
    logic              wr_accept;
    logic              op_hit;
    logic              op_any;
    logic              op_refuse_now;
    logic              wr_prot;
    logic              wr_stat;
    fbp_prot_type      wr_fields;

    assign reg_rdata  = rdata_q;
    assign cfg_rd     = cfg_rd_q;
    assign cfg_addr   = cfg_addr_q;
    assign op_done    = op_done_q;
    assign op_refused = op_refused_q;
    assign loaded     = loaded_q;

    always_comb begin
        case (st_q)
            ST_FETCH0: st_d = ST_FETCH1;
            ST_FETCH1: st_d = ST_CAP0;
            ST_CAP0:   st_d = ST_CAP1;
            ST_CAP1:   st_d = ST_RUN;
            ST_RUN:    st_d = ST_RUN;
            default:   st_d = ST_FETCH0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= ST_FETCH0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_rd_q   <= 1'b0;
            cfg_addr_q <= CFG_ADDR_BLK0;
        end else begin
            case (st_q)
                ST_FETCH0: begin
                    cfg_rd_q   <= 1'b1;
                    cfg_addr_q <= CFG_ADDR_BLK0;
                end
                ST_FETCH1: begin
                    cfg_rd_q   <= 1'b1;
                    cfg_addr_q <= CFG_ADDR_BLK1;
                end
                default: begin
                    cfg_rd_q   <= 1'b0;
                    cfg_addr_q <= cfg_addr_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= (st_q == ST_CAP1) || loaded_q;
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    assign wr_prot = reg_wr && reg_addr == REG_PROT && st_q == ST_RUN;
    assign wr_stat = reg_wr && reg_addr == REG_STATUS;
    assign wr_fields = fbp_prot_type'(reg_wdata);

    fbp_write_filter u_filter (
        .cur    (prot_q[bank_sel_q]),
        .wdata  (fbp_prot_type'(reg_wdata)),
        .next   (wr_next),
        .accept (wr_accept)
    );

    // Each block keeps its own copy; the loaded byte includes the read-only bit.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int b = 0; b < NUM_BLOCKS; b++) begin
                prot_q[b] <= fbp_prot_type'(PROT_RESET_VAL);
            end
        end else begin
            if (st_q == ST_CAP0) begin
                prot_q[0] <= fbp_prot_type'(cfg_data);
            end
            if (st_q == ST_CAP1) begin
                prot_q[1] <= fbp_prot_type'(cfg_data);
            end
            if (wr_prot) begin
                prot_q[bank_sel_q] <= wr_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bank_sel_q <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CONFIG) begin
            bank_sel_q <= reg_wdata[BIT_BANK];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= READ_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_PROT:   rdata_q <= prot_q[bank_sel_q];
                REG_CONFIG: rdata_q <= DATA_W'(bank_sel_q) << BIT_BANK;
                REG_STATUS: rdata_q <= (DATA_W'(viol_q[bank_sel_q]) << BIT_VIOL)
                                     | (DATA_W'(loaded_q) << BIT_LOADED);
                default:    rdata_q <= READ_ZERO;
            endcase
        end else begin
            rdata_q <= READ_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Operation screening
    // ----------------------------------------------------------------
    fbp_range_check u_range (
        .prot          (prot_q[op_req.block]),
        .req           (op_req),
        .protected_hit (op_hit),
        .any_protected (op_any)
    );

    // Until both copies are loaded every operation is refused.
    assign op_refuse_now = !loaded_q
                        || (op_req.kind == OP_MASS_ERASE ? op_any : op_hit);

    always_ff @(posedge clk) begin
        if (reset) begin
            op_done_q    <= 1'b0;
            op_refused_q <= 1'b0;
        end else begin
            op_done_q    <= op_valid;
            op_refused_q <= op_valid && op_refuse_now;
        end
    end

    // Write one clears the selected bank's flag; a new violation wins over the clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            viol_q <= '0;
        end else begin
            for (int b = 0; b < NUM_BLOCKS; b++) begin
                if (op_valid && op_refuse_now && op_req.block == 1'(b)) begin
                    viol_q[b] <= 1'b1;
                end else if (wr_stat && bank_sel_q == 1'(b) && reg_wdata[BIT_VIOL]) begin
                    viol_q[b] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_rsvd_readonly: assert property (@(posedge clk) disable iff (reset)
        wr_prot |=> prot_q[$past(bank_sel_q)].rsvd == $past(prot_q[bank_sel_q].rsvd))
        else $error("Reserved bit changed by a write.");

    a_load_order: assert property (@(posedge clk) disable iff (reset)
        st_q == ST_FETCH1 |-> cfg_rd_q && cfg_addr_q == CFG_ADDR_BLK0
            ##1 cfg_rd_q && cfg_addr_q == CFG_ADDR_BLK1 ##1 !cfg_rd_q)
        else $error("Configuration bytes fetched in the wrong order.");

    a_load_capture: assert property (@(posedge clk) disable iff (reset)
        st_q == ST_CAP0 |=> prot_q[0] == fbp_prot_type'($past(cfg_data)) ##1 loaded_q)
        else $error("Block 0 copy not loaded from configuration byte.");

    a_viol_refuse: assert property (@(posedge clk) disable iff (reset)
        op_valid && loaded_q && op_req.kind != OP_MASS_ERASE && op_hit
            |=> op_done_q && op_refused_q && viol_q[$past(op_req.block)])
        else $error("Protected access not refused or flag not set.");

    a_mass_refused: assert property (@(posedge clk) disable iff (reset)
        op_valid && op_req.kind == OP_MASS_ERASE
            && fbp_scenario(prot_q[op_req.block]) != SCEN_OPEN |=> op_refused_q)
        else $error("Mass erase allowed on a protected block.");

    a_open_allows: assert property (@(posedge clk) disable iff (reset)
        op_valid && loaded_q && fbp_scenario(prot_q[op_req.block]) == SCEN_OPEN
            |=> op_done_q && !op_refused_q)
        else $error("Operation refused on an unprotected block.");

    a_illegal_kept: assert property (@(posedge clk) disable iff (reset)
        wr_prot && !wr_accept |=> prot_q[$past(bank_sel_q)] == $past(prot_q[bank_sel_q])
            && $stable(viol_q))
        else $error("Rejected write altered the register.");

    a_hsize_hold: assert property (@(posedge clk) disable iff (reset)
        wr_prot && !prot_q[bank_sel_q].hdis
            |=> prot_q[$past(bank_sel_q)].hsize == $past(prot_q[bank_sel_q].hsize))
        else $error("High size changed while high range enabled.");

    a_lsize_hold: assert property (@(posedge clk) disable iff (reset)
        wr_prot && !prot_q[bank_sel_q].ldis
            |=> prot_q[$past(bank_sel_q)].lsize == $past(prot_q[bank_sel_q].lsize))
        else $error("Low size changed while low range enabled.");

    a_accept_stored: assert property (@(posedge clk) disable iff (reset)
        wr_prot && wr_accept |=> fbp_scenario(prot_q[$past(bank_sel_q)])
            == fbp_scenario(fbp_prot_type'($past(reg_wdata))))
        else $error("Accepted write does not show the new scenario.");

    // Read answers, bank isolation, size writes, the edges of the windows, operation answers and the violation flag.
    a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
        !reg_rd |=> rdata_q == READ_ZERO)
        else $error("Read data not zero outside the answer cycle.");

    a_prot_read: assert property (@(posedge clk) disable iff (reset)
        reg_rd && reg_addr == REG_PROT |=> rdata_q == $past(prot_q[bank_sel_q]))
        else $error("Read data does not show the selected copy.");

    a_bank_isolated: assert property (@(posedge clk) disable iff (reset)
        wr_prot |=> prot_q[~$past(bank_sel_q)] == $past(prot_q[~bank_sel_q]))
        else $error("Write to one block changed the other block copy.");

    a_hsize_write: assert property (@(posedge clk) disable iff (reset)
        wr_prot && wr_accept && prot_q[bank_sel_q].hdis
            |=> prot_q[$past(bank_sel_q)].hsize == $past(wr_fields.hsize))
        else $error("High size not written while high range disabled.");

    a_lsize_write: assert property (@(posedge clk) disable iff (reset)
        wr_prot && wr_accept && prot_q[bank_sel_q].ldis
            |=> prot_q[$past(bank_sel_q)].lsize == $past(wr_fields.lsize))
        else $error("Low size not written while low range disabled.");

    a_high_protect: assert property (@(posedge clk) disable iff (reset)
        op_valid && loaded_q && op_req.kind != OP_MASS_ERASE && !op_req.paged && &op_req.addr
            && prot_q[op_req.block].func && !prot_q[op_req.block].hdis |=> op_refused_q)
        else $error("Top address not refused inside a protected high range.");

    a_low_open: assert property (@(posedge clk) disable iff (reset)
        op_valid && loaded_q && op_req.kind != OP_MASS_ERASE && !op_req.paged
            && {1'b0, op_req.addr} == UNPAGED_LOW_BASE
            && !prot_q[op_req.block].func && !prot_q[op_req.block].ldis |=> !op_refused_q)
        else $error("Bottom address refused inside an unprotected low range.");

    a_done_idle: assert property (@(posedge clk) disable iff (reset)
        !op_valid |=> !op_done_q && !op_refused_q)
        else $error("Operation answer without a request.");

    a_early_refused: assert property (@(posedge clk) disable iff (reset)
        op_valid && !loaded_q |=> op_refused_q && viol_q[$past(op_req.block)])
        else $error("Operation accepted before the copies were loaded.");

    a_viol_clear: assert property (@(posedge clk) disable iff (reset)
        wr_stat && reg_wdata[BIT_VIOL] && !op_valid |=> !viol_q[$past(bank_sel_q)])
        else $error("Violation flag not cleared by a write of one.");

endmodule : fbp_protect

/* hw/fbp_range_check.sv */
// Purpose: Decides whether one program or erase address lies in a protected area.
// Assumes: Paged requests carry the page number; unpaged ones use the 16-bit address.
// Notes:   Purely combinational.
`timescale 1ns/1ps

module fbp_range_check
    import fbp_pkg::*;
(
    input  fbp_prot_type   prot,      // Protection copy of the addressed block
    input  fbp_op_req_type req,       // Operation under test
    output logic           protected_hit, // Address is guarded
    output logic           any_protected  // Some sector of the block is guarded
);

    logic [16:0] hi_bytes;
    logic [16:0] lo_bytes;
    logic [16:0] addr17;
    logic        in_hi;
    logic        in_lo;
    logic        hi_act;
    logic        lo_act;

    always_comb begin
        hi_bytes = HIGH_MIN_BYTES << prot.hsize;
        lo_bytes = LOW_MIN_BYTES << prot.lsize;
        addr17   = {1'b0, req.addr};
        if (req.paged) begin
            in_hi = (req.page == PAGE_HIGH_A || req.page == PAGE_HIGH_B)
                 && addr17 >= (PAGED_HIGH_END - hi_bytes) && addr17 < PAGED_HIGH_END;
            in_lo = (req.page == PAGE_LOW_A || req.page == PAGE_LOW_B)
                 && addr17 >= PAGED_LOW_BASE && addr17 < (PAGED_LOW_BASE + lo_bytes);
        end else begin
            in_hi = addr17 >= (UNPAGED_HIGH_END - hi_bytes);
            in_lo = addr17 >= UNPAGED_LOW_BASE && addr17 < (UNPAGED_LOW_BASE + lo_bytes);
        end
        hi_act = !prot.hdis && in_hi;
        lo_act = !prot.ldis && in_lo;
        protected_hit = prot.func ? (hi_act || lo_act) : !(hi_act || lo_act);
        any_protected = fbp_scenario(prot) != SCEN_OPEN;
    end

endmodule : fbp_range_check

/* hw/fbp_write_filter.sv */
// Purpose: Builds the value a software write would leave and checks the transition.
// Assumes: The current value is that of the bank being written.
// Notes:   A refused write returns the current value unchanged.
`timescale 1ns/1ps

module fbp_write_filter
    import fbp_pkg::*;
(
    input  fbp_prot_type cur,     // Present register contents
    input  fbp_prot_type wdata,   // Value software writes
    output fbp_prot_type next,    // Value to store
    output logic         accept   // Transition is allowed
);

    fbp_prot_type cand;

    always_comb begin
        cand       = wdata;
        cand.rsvd  = cur.rsvd;
        cand.hsize = cur.hdis ? wdata.hsize : cur.hsize;
        cand.lsize = cur.ldis ? wdata.lsize : cur.lsize;
        accept     = fbp_trans_ok(fbp_scenario(cur), fbp_scenario(cand));
        next       = accept ? cand : cur;
    end

endmodule : fbp_write_filter

/* tb/fbp_protect_bench.sv */
// Purpose: Self-checking bench of the banked block protection register.
// Assumes: Config memory answers in the cycle after its read request.
// Notes:   Expected values come from a local model of the register and windows.
`timescale 1ns/1ps

module fbp_protect_bench
    import fbp_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic              clk       = 1'b0;
    logic              reset     = 1'b1;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              cfg_rd;
    logic [15:0]       cfg_addr;
    logic [DATA_W-1:0] cfg_data  = '0;
    logic              op_valid  = 1'b0;
    fbp_op_req_type    op_req    = '0;
    logic              op_done;
    logic              op_refused;
    logic              loaded;
    logic [7:0]        cfg_b [2];
    logic [7:0]        prot_m [2];
    logic              viol_m [2];
    logic              bank_m;
    logic [7:0]        rdq [$];
    logic              opq [$];
    logic              rd_p      = 1'b0;
    logic              op_p      = 1'b0;
    logic [7:0]        allow [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
    logic [15:0]       bases [16] = '{16'h4000, 16'h43ff, 16'h47ff, 16'h4fff, 16'h5fff, 16'h8000,
                                      16'h83ff, 16'h9fff, 16'hafff, 16'hc000, 16'hc7ff, 16'hcfff,
                                      16'hdfff, 16'hefff, 16'hf7ff, 16'hffff};
    logic [7:0]        pages [5] = '{8'h37, 8'h3f, 8'h36, 8'h3e, 8'h30};
    int                fail_count = 0;
    int                num_checks = 0;

    always #5 clk = ~clk;

    fbp_protect uut (
        .clk        (clk),
        .reset      (reset),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .cfg_rd     (cfg_rd),
        .cfg_addr   (cfg_addr),
        .cfg_data   (cfg_data),
        .op_valid   (op_valid),
        .op_req     (op_req),
        .op_done    (op_done),
        .op_refused (op_refused),
        .loaded     (loaded)
    );

    // Config memory: a byte only for a matching request, a toggling pattern otherwise.
    always @(posedge clk) begin
        if (cfg_rd && cfg_addr == 16'hff0d) cfg_data <= cfg_b[0];
        else if (cfg_rd && cfg_addr == 16'hff0c) cfg_data <= cfg_b[1];
        else cfg_data <= ~cfg_data;
    end

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_p <= reg_rd;
        op_p <= op_valid;
    end

    always @(negedge clk) begin
        if (rd_p) check("reg_rdata", reg_rdata, rdq.pop_front());
        else check("reg_rdata idle", reg_rdata, 8'h00);
        check("op_done", {7'h0, op_done}, {7'h0, op_p});
        if (op_p) check("op_refused", {7'h0, op_refused}, {7'h0, opq.pop_front()});
        else check("op_refused idle", {7'h0, op_refused}, 8'h00);
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Model and drivers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] p, input fbp_op_req_type q);
        logic [15:0] hb;
        logic [15:0] ht;
        logic [15:0] lb;
        logic [15:0] lt;
        logic        ih;
        logic        il;
        hb = q.paged ? 16'hd000 - (16'h0800 << p[4:3]) : 16'hf800 << p[4:3];
        ht = q.paged ? 16'hcfff : 16'hffff;
        lb = q.paged ? 16'h8000 : 16'h4000;
        lt = (16'h0400 << p[1:0]) - 16'h0001;
        ih = !p[5] && (!q.paged || q.page inside {8'h37, 8'h3f}) && q.addr >= hb && q.addr <= ht;
        il = !p[2] && (!q.paged || q.page inside {8'h36, 8'h3e}) && q.addr >= lb && q.addr <= lb + lt;
        return p[7] ? (ih || il) : !(ih || il);
    endfunction : hit

    function automatic logic [7:0] model_rd(input logic [3:0] a);
        case (a)
            REG_PROT:   return prot_m[bank_m];
            REG_CONFIG: return {7'h0, bank_m};
            REG_STATUS: return {1'b1, 1'b0, viol_m[bank_m], 5'h0};
            default:    return 8'h00;
        endcase
    endfunction : model_rd

    task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= r;
        op_valid  <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] c;
        logic [7:0] n;
        c = prot_m[bank_m];
        n = {d[7], c[6], d[5], c[5] ? d[4:3] : c[4:3], d[2], c[2] ? d[1:0] : c[1:0]};
        if (a == REG_PROT && allow[{c[7], c[5], c[2]}][{n[7], n[5], n[2]}]) prot_m[bank_m] = n;
        if (a == REG_STATUS && d[5]) viol_m[bank_m] = 1'b0;
        if (a == REG_CONFIG) bank_m = d[0];
        bus(a, d, 1'b1, 1'b0);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        rdq.push_back(model_rd(a));
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask : rd

    task automatic op(input fbp_op_req_type q, input logic ready);
        logic [7:0] p;
        logic       refuse;
        p = prot_m[q.block];
        refuse = !ready || (q.kind == OP_MASS_ERASE ? {p[7], p[5], p[2]} != 3'h7 : hit(p, q));
        opq.push_back(refuse);
        if (refuse) viol_m[q.block] = 1'b1;
        op_req   <= q;
        op_valid <= 1'b1;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b0;
        @(posedge clk);
        bus(4'h0, 8'h00, 1'b0, 1'b0);
    endtask : op

    task automatic run_phase(input logic [7:0] b0, input logic [7:0] b1, input int sweep_from);
        fbp_op_req_type q;
        int             k;
        logic [2:0]     s;
        reset <= 1'b1;
        repeat (4) bus(4'h0, 8'h00, 1'b0, 1'b0);
        // Stored bytes are rewritten only while reset holds the block, never under live protection.
        cfg_b[0] = b0;
        cfg_b[1] = b1;
        reset <= 1'b0;
        viol_m = '{1'b0, 1'b0};
        bank_m = 1'b0;
        prot_m = '{b0, b1};
        q = '0;
        op(q, 1'b0);
        k = 0;
        while (loaded !== 1'b1 && k < 20) begin
            bus(4'h0, 8'h00, 1'b0, 1'b0);
            k++;
        end
        if (k == 20) begin
            fail_count++;
            finish_test();
        end
        rd(REG_PROT);
        rd(REG_STATUS);
        wr(REG_CONFIG, 8'h01);
        rd(REG_PROT);
        for (int i = sweep_from; i >= 0; i--) begin
            s = 3'(i);
            wr(REG_PROT, {s[2], 1'b0, s[1], 2'($urandom_range(3)), s[0], 2'($urandom_range(3))});
            rd(REG_PROT);
        end
        for (int i = 0; i < 150; i++) begin
            case ($urandom_range(5))
                0: begin
                    wr(REG_PROT, 8'($urandom));
                    rd(REG_PROT);
                end
                1: rd(4'($urandom_range(4)));
                2: wr(4'($urandom_range(4)), 8'($urandom));
                3: rd(REG_STATUS);
                default: begin
                    q.kind  = fbp_op_kind_type'(2'($urandom_range(2)));
                    q.block = 1'($urandom_range(1));
                    q.paged = 1'($urandom_range(1));
                    q.page  = pages[$urandom_range(4)];
                    q.addr  = bases[$urandom_range(15)] + 16'($urandom_range(2)) - 16'h0001;
                    // Addresses below the widest paged high window are not settled, so they are moved into it.
                    if (q.paged && q.page[0] && q.addr < 16'h9000) q.addr[15:12] = 4'h9;
                    op(q, 1'b1);
                end
            endcase
        end
    endtask : run_phase

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hd1ef));
        @(posedge clk);
        run_phase(8'hff, 8'hff, 7);
        run_phase(8'h5b, 8'hd2, 7);
        run_phase(8'h7f, 8'he6, 5);
        repeat (3) bus(4'h0, 8'h00, 1'b0, 1'b0);
        finish_test();
    end

    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        finish_test();
    end

endmodule : fbp_protect_bench
